/* File: rtl/lcbe_pkg.sv */
// Contract
// - each luma sample is multiplied by a six-bit contrast setting
// - contrast maps to gain zero to just under two (63/32); setting 32 is exactly unity
// - separate contrast settings for main and side picture
// - separate expander coefficient sets for main and side, chosen per sample
// - min and max of low-passed luma plus tilt coefficient give tilt point
// - below tilt point output is input plus gain times input minus tilt
// - at or above tilt point the expander passes the sample unchanged
// - inputs above the programmable upper threshold are never expanded
// - small measured range puts tilt at zero so nothing is expanded
package lcbe_pkg;

   localparam int LUMA_W = 10;
   localparam int CON_W = 6;
   localparam int COEF_W = 4;
   localparam logic [LUMA_W-1:0] LUMA_FULL = 10'h3ff;
   localparam logic [CON_W-1:0] CON_UNITY = 6'h20;
   localparam int CON_SHIFT = 5;
   localparam int GAIN_SHIFT = 4;
   localparam int LPF_SHIFT = 2;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CON_MAIN = 8'h04;
   localparam logic [7:0] OFS_CON_SIDE = 8'h08;
   localparam logic [7:0] OFS_EXP_MAIN = 8'h0c;
   localparam logic [7:0] OFS_EXP_SIDE = 8'h10;
   localparam logic [7:0] OFS_UTHR_MAIN = 8'h14;
   localparam logic [7:0] OFS_UTHR_SIDE = 8'h18;
   localparam logic [7:0] OFS_RANGE_MIN = 8'h1c;
   localparam logic [7:0] OFS_MEAS = 8'h20;
   localparam logic [7:0] OFS_TILT = 8'h24;

   // field positions
   localparam int CTRL_EXP_EN = 0;
   localparam int EXP_GAIN_LSB = 0;
   localparam int EXP_COEF_LSB = 4;
   localparam int HI_HALF_LSB = 16;

   // reset values
   localparam logic RST_EXP_EN = 1'b0;
   localparam logic [COEF_W-1:0] RST_GAIN = 4'h0;
   localparam logic [COEF_W-1:0] RST_COEF = 4'h4;
   localparam logic [LUMA_W-1:0] RST_UTHR = 10'h3ff;
   localparam logic [LUMA_W-1:0] RST_RANGE_MIN = 10'h100;

   // clamp a signed intermediate to the luma range
   function automatic logic [LUMA_W-1:0] lcbe_sat(input logic signed [17:0] v);
      if (v < 18'sd0) begin
         return '0;
      end
      if (v > $signed({8'h00, LUMA_FULL})) begin
         return LUMA_FULL;
      end
      return v[LUMA_W-1:0];
   endfunction

   // tilt point from measured range and coefficient, zero for small range
   function automatic logic [LUMA_W-1:0] lcbe_tilt(input logic [LUMA_W-1:0] mn,
         input logic [LUMA_W-1:0] mx, input logic [COEF_W-1:0] coef,
         input logic [LUMA_W-1:0] rangeMin);
      logic [LUMA_W-1:0] rng;
      logic [13:0] prod;
      rng = mx - mn;
      prod = rng * coef;
      if (rng < rangeMin) begin
         return '0;
      end
      return mn + prod[13:GAIN_SHIFT];
   endfunction

endpackage

/* File: rtl/lcbe_contrast.sv */
`timescale 1ns/1ps
module lcbe_contrast
   import lcbe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [LUMA_W-1:0] lumaIn,
   input wire logic lumaValid,
   input wire logic sideSel,
   input wire logic [CON_W-1:0] conMain,
   input wire logic [CON_W-1:0] conSide,
   output logic [LUMA_W-1:0] lumaQ,
   output logic validQ,
   output logic sideQ
);

   logic [CON_W-1:0] conSel;
   logic [15:0] prod;

   // gain is setting / 32, so 32 is unity and 63 just under two
   assign conSel = sideSel ? conSide : conMain;
   assign prod = lumaIn * conSel;

   // scaled sample, clamped to full scale
   always_ff @(posedge clk) begin
      if (rst) begin
         lumaQ <= '0;
         validQ <= 1'b0;
         sideQ <= 1'b0;
      end else begin
         lumaQ <= lcbe_sat($signed({2'b00, prod}) >>> CON_SHIFT);
         validQ <= lumaValid;
         sideQ <= sideSel;
      end
   end

   a_unity_gain: assert property (@(posedge clk) disable iff (rst)
      lumaValid && conSel == CON_UNITY |=> lumaQ == $past(lumaIn))
      else $error("unity contrast altered the sample");

   // full sixteen-bit product, checked only for side products below 16'h8000
   a_side_contrast: assert property (@(posedge clk) disable iff (rst)
      lumaValid && sideSel && (lumaIn * conSide) < 16'h8000 |=>
      lumaQ == lcbe_sat($signed({2'b00, 16'($past(lumaIn) * $past(conSide))})
         >>> CON_SHIFT))
      else $error("side picture did not use side contrast");

   a_contrast_clip: assert property (@(posedge clk) disable iff (rst)
      lumaValid && prod[15:CON_SHIFT] > 11'h3ff |=> lumaQ == LUMA_FULL)
      else $error("contrast overflow not clamped");

endmodule

/* File: rtl/lcbe_range_meter.sv */
`timescale 1ns/1ps
module lcbe_range_meter
   import lcbe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [LUMA_W-1:0] luma,
   input wire logic lumaValid,
   input wire logic fieldStart,
   output logic [LUMA_W-1:0] measMin,
   output logic [LUMA_W-1:0] measMax,
   output logic measValid
);

   logic [LUMA_W-1:0] lpQ;
   logic [LUMA_W-1:0] runMinQ;
   logic [LUMA_W-1:0] runMaxQ;
   logic seenQ;
   logic signed [LUMA_W:0] step;
   logic [LUMA_W-1:0] lpNext;

   // filter step and the filter output that includes this sample
   assign step = ($signed({1'b0, luma}) - $signed({1'b0, lpQ})) >>> LPF_SHIFT;
   assign lpNext = LUMA_W'($signed({1'b0, lpQ}) + step);

   // first-order low-pass of the luma stream
   always_ff @(posedge clk) begin
      if (rst) begin
         lpQ <= '0;
      end else if (lumaValid) begin
         lpQ <= lpNext;
      end
   end

   // running extremes over one field, handed over at the field boundary
   always_ff @(posedge clk) begin
      if (rst) begin
         runMinQ <= LUMA_FULL;
         runMaxQ <= '0;
         seenQ <= 1'b0;
         measMin <= '0;
         measMax <= '0;
         measValid <= 1'b0;
      end else begin
         measValid <= fieldStart && seenQ;
         if (fieldStart) begin
            if (seenQ) begin
               measMin <= runMinQ;
               measMax <= runMaxQ;
            end
            runMinQ <= LUMA_FULL;
            runMaxQ <= '0;
            seenQ <= 1'b0;
         end else if (lumaValid) begin
            seenQ <= 1'b1;
            // extremes follow the filter output, this sample included
            if (lpNext < runMinQ) runMinQ <= lpNext;
            if (lpNext > runMaxQ) runMaxQ <= lpNext;
         end
      end
   end

   a_meas_order: assert property (@(posedge clk) disable iff (rst)
      measValid |-> measMin <= measMax)
      else $error("field minimum above maximum");

endmodule

/* File: rtl/lcbe_top.sv */
`timescale 1ns/1ps
module lcbe_top
   import lcbe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [LUMA_W-1:0] lumaIn,
   input wire logic lumaValid,
   input wire logic sideSel,
   input wire logic fieldStart,
   output logic [LUMA_W-1:0] lumaOut,
   output logic lumaOutValid,
   output logic lumaOutSide
);

   // control registers
   logic expEnQ;
   logic [CON_W-1:0] conMainQ;
   logic [CON_W-1:0] conSideQ;
   logic [COEF_W-1:0] gainMainQ;
   logic [COEF_W-1:0] gainSideQ;
   logic [COEF_W-1:0] coefMainQ;
   logic [COEF_W-1:0] coefSideQ;
   logic [LUMA_W-1:0] uthrMainQ;
   logic [LUMA_W-1:0] uthrSideQ;
   logic [LUMA_W-1:0] rangeMinQ;
   logic [LUMA_W-1:0] tiltMainQ;
   logic [LUMA_W-1:0] tiltSideQ;

   // bus handshake
   logic ackQ;
   logic [31:0] datOQ;
   logic wrEn;
   logic [31:0] rdData;
   logic [31:0] wrWord;

   // pipeline nets
   logic [LUMA_W-1:0] conLuma;
   logic conValid;
   logic conSide;
   logic [LUMA_W-1:0] measMin;
   logic [LUMA_W-1:0] measMax;
   logic measValid;

   // expander nets
   logic [LUMA_W-1:0] tiltSel;
   logic [LUMA_W-1:0] uthrSel;
   logic [COEF_W-1:0] gainSel;
   logic doExpand;
   logic signed [LUMA_W:0] diff;
   logic signed [15:0] term;
   logic [LUMA_W-1:0] expanded;
   logic [LUMA_W-1:0] lumaOutQ;
   logic outValidQ;
   logic outSideQ;

   // byte-lane merge of a write into a register image
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) res[i*8 +: 8] = wr[i*8 +: 8];
      end
      return res;
   endfunction

   // ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk) begin
      if (rst) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= cyc_i && stb_i && !ackQ;
      end
   end

   assign ack_o = ackQ;
   assign wrEn = cyc_i && stb_i && we_i && ackQ;

   // read mux, unmapped addresses read zero
   always_comb begin
      rdData = '0;
      case (adr_i)
         OFS_CTRL: rdData[CTRL_EXP_EN] = expEnQ;
         OFS_CON_MAIN: rdData[CON_W-1:0] = conMainQ;
         OFS_CON_SIDE: rdData[CON_W-1:0] = conSideQ;
         OFS_EXP_MAIN: rdData[7:0] = {coefMainQ, gainMainQ};
         OFS_EXP_SIDE: rdData[7:0] = {coefSideQ, gainSideQ};
         OFS_UTHR_MAIN: rdData[LUMA_W-1:0] = uthrMainQ;
         OFS_UTHR_SIDE: rdData[LUMA_W-1:0] = uthrSideQ;
         OFS_RANGE_MIN: rdData[LUMA_W-1:0] = rangeMinQ;
         OFS_MEAS: begin
            rdData[LUMA_W-1:0] = measMin;
            rdData[HI_HALF_LSB +: LUMA_W] = measMax;
         end
         OFS_TILT: begin
            rdData[LUMA_W-1:0] = tiltMainQ;
            rdData[HI_HALF_LSB +: LUMA_W] = tiltSideQ;
         end
         default: rdData = '0;
      endcase
   end

   // write image: the addressed register with the enabled lanes replaced
   assign wrWord = merge(rdData, dat_i, sel_i);

   // read data captured with the ack
   always_ff @(posedge clk) begin
      if (rst) begin
         datOQ <= '0;
      end else if (cyc_i && stb_i && !ackQ) begin
         datOQ <= we_i ? 32'h0000_0000 : rdData;
      end
   end

   assign dat_o = datOQ;

   // register writes, applied at the ack edge
   always_ff @(posedge clk) begin
      if (rst) begin
         expEnQ <= RST_EXP_EN;
         conMainQ <= CON_UNITY;
         conSideQ <= CON_UNITY;
         gainMainQ <= RST_GAIN;
         gainSideQ <= RST_GAIN;
         coefMainQ <= RST_COEF;
         coefSideQ <= RST_COEF;
         uthrMainQ <= RST_UTHR;
         uthrSideQ <= RST_UTHR;
         rangeMinQ <= RST_RANGE_MIN;
      end else if (wrEn) begin
         case (adr_i)
            OFS_CTRL: expEnQ <= wrWord[CTRL_EXP_EN];
            OFS_CON_MAIN: conMainQ <= wrWord[CON_W-1:0];
            OFS_CON_SIDE: conSideQ <= wrWord[CON_W-1:0];
            OFS_EXP_MAIN: begin
               gainMainQ <= wrWord[EXP_GAIN_LSB +: COEF_W];
               coefMainQ <= wrWord[EXP_COEF_LSB +: COEF_W];
            end
            OFS_EXP_SIDE: begin
               gainSideQ <= wrWord[EXP_GAIN_LSB +: COEF_W];
               coefSideQ <= wrWord[EXP_COEF_LSB +: COEF_W];
            end
            OFS_UTHR_MAIN: uthrMainQ <= wrWord[LUMA_W-1:0];
            OFS_UTHR_SIDE: uthrSideQ <= wrWord[LUMA_W-1:0];
            OFS_RANGE_MIN: rangeMinQ <= wrWord[LUMA_W-1:0];
            default: expEnQ <= expEnQ;
         endcase
      end
   end

   // contrast stage
   lcbe_contrast uContrast (
      .clk(clk),
      .rst(rst),
      .lumaIn(lumaIn),
      .lumaValid(lumaValid),
      .sideSel(sideSel),
      .conMain(conMainQ),
      .conSide(conSideQ),
      .lumaQ(conLuma),
      .validQ(conValid),
      .sideQ(conSide)
   );

   // field extremes of the contrast-scaled luma
   lcbe_range_meter uMeter (
      .clk(clk),
      .rst(rst),
      .luma(conLuma),
      .lumaValid(conValid),
      .fieldStart(fieldStart),
      .measMin(measMin),
      .measMax(measMax),
      .measValid(measValid)
   );

   // tilt points refreshed once per field for each picture
   always_ff @(posedge clk) begin
      if (rst) begin
         tiltMainQ <= '0;
         tiltSideQ <= '0;
      end else if (measValid) begin
         tiltMainQ <= lcbe_tilt(measMin, measMax, coefMainQ, rangeMinQ);
         tiltSideQ <= lcbe_tilt(measMin, measMax, coefSideQ, rangeMinQ);
      end
   end

   // per-picture coefficient set
   assign tiltSel = conSide ? tiltSideQ : tiltMainQ;
   assign uthrSel = conSide ? uthrSideQ : uthrMainQ;
   assign gainSel = conSide ? gainSideQ : gainMainQ;

   // expand only below tilt and not above the upper threshold
   assign doExpand = expEnQ && conLuma < tiltSel && conLuma <= uthrSel;
   assign diff = $signed({1'b0, conLuma}) - $signed({1'b0, tiltSel});
   assign term = (16'(diff) * $signed({1'b0, gainSel})) >>> GAIN_SHIFT;
   assign expanded = lcbe_sat(18'($signed({1'b0, conLuma})) + 18'(term));

   // expander output register
   always_ff @(posedge clk) begin
      if (rst) begin
         lumaOutQ <= '0;
         outValidQ <= 1'b0;
         outSideQ <= 1'b0;
      end else begin
         lumaOutQ <= doExpand ? expanded : conLuma;
         outValidQ <= conValid;
         outSideQ <= conSide;
      end
   end

   assign lumaOut = lumaOutQ;
   assign lumaOutValid = outValidQ;
   assign lumaOutSide = outSideQ;

   sequence sFieldDone;
      measValid ##1 1'b1;
   endsequence

   sequence sSmallRange;
      measValid && (measMax - measMin) < rangeMinQ;
   endsequence

   sequence sSideConWrite;
      cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CON_SIDE && sel_i[0];
   endsequence

   a_small_range: assert property (@(posedge clk) disable iff (rst)
      sSmallRange |=> tiltMainQ == '0 && tiltSideQ == '0)
      else $error("small range left a nonzero tilt");

   a_tilt_hold: assert property (@(posedge clk) disable iff (rst)
      !measValid |=> $stable(tiltMainQ) && $stable(tiltSideQ))
      else $error("tilt changed outside a field update");

   a_tilt_bounds: assert property (@(posedge clk) disable iff (rst)
      measValid && (measMax - measMin) >= rangeMinQ ##0 sFieldDone |->
      tiltMainQ >= $past(measMin) && tiltMainQ <= $past(measMax))
      else $error("tilt outside measured range");

   a_pass_above: assert property (@(posedge clk) disable iff (rst)
      conValid && conLuma >= tiltSel |=> lumaOut == $past(conLuma))
      else $error("sample above tilt was modified");

   a_upper_thr: assert property (@(posedge clk) disable iff (rst)
      conValid && conLuma > uthrSel |=> lumaOut == $past(conLuma))
      else $error("sample above upper threshold was expanded");

   a_expand_below: assert property (@(posedge clk) disable iff (rst)
      conValid && expEnQ && conLuma < tiltSel && conLuma <= uthrSel && gainSel != '0 |=>
      lumaOut < $past(conLuma) || lumaOut == '0)
      else $error("dark sample not pushed toward black");

   a_side_set: assert property (@(posedge clk) disable iff (rst)
      conValid && conSide && !expEnQ |=> lumaOutSide && lumaOut == $past(conLuma))
      else $error("side flag or bypass lost in expander");

   // each accepted sample leaves two edges later with its picture flag
   a_out_latency: assert property (@(posedge clk) disable iff (rst)
      lumaValid |-> ##2 lumaOutValid && lumaOutSide == $past(sideSel, 2))
      else $error("output sample late or side flag lost");

   // no output sample without an input sample
   a_no_phantom: assert property (@(posedge clk) disable iff (rst)
      !lumaValid |-> ##2 !lumaOutValid)
      else $error("output valid without an input sample");

   // a side contrast write lands at the ack edge
   a_side_write: assert property (@(posedge clk) disable iff (rst)
      sSideConWrite |=> conSideQ == $past(dat_i[CON_W-1:0]))
      else $error("side contrast write did not land");

   // zero expansion gain leaves the sample alone
   a_gain_zero: assert property (@(posedge clk) disable iff (rst)
      conValid && gainSel == '0 |=> lumaOut == $past(conLuma))
      else $error("zero gain still changed the sample");

   // expander switched off passes the contrast result
   a_bypass_off: assert property (@(posedge clk) disable iff (rst)
      conValid && !expEnQ |=> lumaOut == $past(conLuma))
      else $error("disabled expander changed the sample");

   // equal coefficients give equal tilt points for both pictures
   a_coef_same: assert property (@(posedge clk) disable iff (rst)
      measValid && coefMainQ == coefSideQ |=> tiltMainQ == tiltSideQ)
      else $error("tilt points differ for equal coefficients");

   a_bus_ack: assert property (@(posedge clk) disable iff (rst)
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus ack not a single cycle");

endmodule

/* File: verif/lcbe_luma_src.sv */
`timescale 1ns/1ps
module lcbe_luma_src
   import lcbe_pkg::*;
(
   input wire logic clk,
   output logic [LUMA_W-1:0] lumaIn,
   output logic lumaValid,
   output logic sideSel,
   output logic fieldStart
);
   // idle pins at time zero
   initial begin
      lumaIn = '0;
      lumaValid = 1'b0;
      sideSel = 1'b0;
      fieldStart = 1'b0;
   end
   // one sample per edge, back to back allowed
   task automatic send(input logic [LUMA_W-1:0] v, input logic s);
      @(posedge clk);
      lumaIn <= v;
      lumaValid <= 1'b1;
      sideSel <= s;
      fieldStart <= 1'b0;
   endtask
   // idle cycles with scrambled data, field pulse once the last sample is in
   task automatic idle(input int n, input logic fs);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         lumaValid <= 1'b0;
         lumaIn <= ~lumaIn;
         sideSel <= ~sideSel;
         fieldStart <= fs && (i == 1);
      end
   endtask
endmodule

/* File: verif/test_luma_contrast_black_expander.sv */
`timescale 1ns/1ps
module test_luma_contrast_black_expander;
   import lcbe_pkg::*;
   logic clk, rst, cyc, stb, we, ack;
   logic [7:0] adr;
   logic [31:0] datW, datR, seed, meas;
   logic [3:0] sel;
   logic [LUMA_W-1:0] lumaIn, lumaOut;
   logic lumaValid, sideSel, fieldStart, outValid, outSide;
   int failures, n_checks, en, rngMin, lp, mn, mx;
   int con[2], gain[2], coef[2], uthr[2], tilt[2];
   logic [10:0] expQ[$];

   lcbe_top u_lcbe_top (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(datW), .sel_i(sel), .dat_o(datR), .ack_o(ack),
      .lumaIn(lumaIn), .lumaValid(lumaValid), .sideSel(sideSel),
      .fieldStart(fieldStart), .lumaOut(lumaOut), .lumaOutValid(outValid),
      .lumaOutSide(outSide));
   lcbe_luma_src u_lcbe_luma_src (.clk(clk), .lumaIn(lumaIn), .lumaValid(lumaValid),
      .sideSel(sideSel), .fieldStart(fieldStart));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic int sat(input int v);
      return v < 0 ? 0 : (v > 1023 ? 1023 : v);
   endfunction
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      r = datR;
      if (ack !== 1'b1) begin
         failures++;
         summarize();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(nm, r, e);
   endtask
   // sample with its expected output noted
   task automatic put(input int v, input int s);
      int c, e;
      c = sat((v * con[s]) >>> 5);
      e = c;
      if (en != 0 && c < tilt[s] && c <= uthr[s])
         e = sat(c + (((c - tilt[s]) * gain[s]) >>> 4));
      lp = lp + ((c - lp) >>> 2);
      if (lp < mn) mn = lp;
      if (lp > mx) mx = lp;
      expQ.push_back({s[0], e[9:0]});
      u_lcbe_luma_src.send(v[9:0], s[0]);
   endtask
   // field pulse and tilt model
   task automatic field();
      int r;
      u_lcbe_luma_src.idle(4, 1'b1);
      r = mx - mn;
      meas = {6'h0, mx[9:0], 6'h0, mn[9:0]};
      for (int p = 0; p < 2; p++)
         tilt[p] = (r < rngMin) ? 0 : mn + ((r * coef[p]) >>> 4);
      mn = 1023;
      mx = 0;
   endtask
   task automatic drain();
      u_lcbe_luma_src.idle(1, 1'b0);
      for (int k = 0; k < 30 && expQ.size() > 0; k++)
         @(posedge clk);
      if (expQ.size() > 0) begin
         failures++;
         summarize();
      end
   endtask

   // compare each output sample with the oldest note
   always @(posedge clk) begin
      if (outValid === 1'b1) begin
         if (expQ.size() == 0) chk("spare", 32'h1, 32'h0);
         else chk("luma", {outSide, lumaOut}, expQ.pop_front());
      end
   end

   // main sequence
   initial begin
      logic [7:0] ra[11] = '{OFS_CTRL, OFS_CON_MAIN, OFS_CON_SIDE, OFS_EXP_MAIN,
         OFS_EXP_SIDE, OFS_UTHR_MAIN, OFS_UTHR_SIDE, OFS_RANGE_MIN, OFS_MEAS, OFS_TILT, 8'h3c};
      logic [31:0] rv[11] = '{32'h0, 32'h20, 32'h20, 32'h40, 32'h40, 32'h3ff, 32'h3ff,
         32'h100, 32'h0, 32'h0, 32'h0};
      int ct[4] = '{0, 32, 63, 17};
      int t;
      seed = 32'd29194;
      failures = 0;
      n_checks = 0;
      con = '{32, 32};
      gain = '{0, 0};
      coef = '{4, 4};
      uthr = '{1023, 1023};
      tilt = '{0, 0};
      en = 0;
      rngMin = 256;
      lp = 0;
      mn = 1023;
      mx = 0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      datW = 32'h0;
      sel = 4'hf;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++)
         rdChk("reset", ra[i], rv[i]);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         con[0] = ct[i];
         con[1] = rnd() % 64;
         wr(OFS_CON_MAIN, con[0]);
         wr(OFS_CON_SIDE, con[1]);
         rdChk("con side", OFS_CON_SIDE, con[1]);
         for (int j = 0; j < 12; j++)
            put(rnd() % 1024, rnd() % 2);
         drain();
      end
      $display("test contrast done");
      con[0] = 32;
      wr(OFS_CON_MAIN, 32'h20);
      for (int j = 0; j < 60; j++)
         put(0, 0);
      field();
      gain = '{12, 5};
      coef = '{4, 8};
      uthr[0] = 128;
      wr(OFS_EXP_MAIN, 32'h4c);
      wr(OFS_EXP_SIDE, 32'h85);
      wr(OFS_UTHR_MAIN, 32'h80);
      for (int j = 0; j < 48; j++)
         put(j < 8 ? 0 : 1023, 0);
      field();
      drain();
      rdChk("meas", OFS_MEAS, meas);
      rdChk("tilt", OFS_TILT, {6'h0, tilt[1][9:0], 6'h0, tilt[0][9:0]});
      rdChk("gain side", OFS_EXP_SIDE, 32'h85);
      en = 1;
      wr(OFS_CTRL, 32'h1);
      for (int s = 0; s < 2; s++) begin
         t = tilt[s];
         foreach (ct[i])
            put(ct[i] * 4, s);
         for (int d = -1; d < 2; d++)
            put(sat(t + d), s);
         put(128, s);
         put(129, s);
         for (int j = 0; j < 10; j++)
            put(rnd() % 1024, rnd() % 2);
      end
      drain();
      $display("test expander done");
      rngMin = 1023;
      wr(OFS_RANGE_MIN, 32'h3ff);
      for (int j = 0; j < 30; j++)
         put(512, 0);
      field();
      rdChk("tilt zero", OFS_TILT, 32'h0);
      for (int j = 0; j < 10; j++)
         put(rnd() % 400, rnd() % 2);
      drain();
      $display("test small range done");
      summarize();
   end
endmodule
